/* File: verilog/tscs_scheduler.sv */
// Timestamped sample capture scheduler for a four-channel input module.
// Assumes the head module gives synchronous one-cycle pulses for the bus
// cycle and timer sync, a level for isochronous mode, and byte-wide
// parameter access by subindex. Converter data is valid whenever sampled.
//
// Functional notes
// - Output apply pulse 200us after reference
// - Input read pulse 230us after reference
// - 32-bit ns counter, head syncs it
// - Latch counter at each module cycle start
// - Iso: up to four samples, image at end
// - Image holds previous cycle's samples, timestamp
// - Oversampling change in iso raises error
// - Factor change in iso raises error
// - Iso mode ignores stored free cycle time
// - Half factor: second cycle overwrites first
// - Free mode: counter from start-up, unsynced
// - Free mode: fixed grid, image plus timestamp
// - Free mode period from cycle time select
// - Free mode stores but ignores factor
// - Diagnostics on at 40h, off at 00h
// - One byte per subindex from 01h
// - Function bytes reset FFh, channel 0 06h
// - Cycle factor resets 02h at 05h
// - Function FFh means channel not sampled
// - Oversampling 00h/01h/02h gives 1/2/4
// - Free cycle 01h..0Ah doubling, default 05h
// - Factor 00h..04h: quarter to quadruple
`timescale 1ns/10ps
`default_nettype none

module tscs_scheduler #(
  parameter int unsigned FREE_BASE_CYC = tscs_pkg::FREE_BASE_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 iso_mode,
  input  wire logic                 bus_cycle,
  input  wire logic                 timer_sync,
  input  wire logic [31:0]          timer_sync_value,
  input  wire logic [3:0][15:0]     adc_data,
  input  wire logic                 param_wr,
  input  wire logic                 param_rd,
  input  wire logic [7:0]           fieldbus_subindex,
  input  wire logic [7:0]           param_wdata,
  output logic      [7:0]           param_rdata,
  output tscs_pkg::tscs_image_s     input_image_area,
  output logic                      image_valid,
  output logic                      sample_strobe,
  output logic                      output_apply,
  output logic                      input_read,
  output logic                      iso_config_error,
  output logic [31:0]               ns_timer,
  output logic [3:0]                channel_active,
  output logic                      diag_interrupt_enable,
  output logic [3:0]                wire_break_enable
);

  tscs_pkg::tscs_state_s q, d;

  // Samples per cycle as a shift: 00h one, 01h two, 02h four
  function automatic logic [1:0] ovs_shift(input logic [7:0] v);
    ovs_shift = (v > tscs_pkg::OVS_MAX) ? 2'h2 : v[1:0];
  endfunction

  // Free period doubles per step from the 62.5us base
  function automatic logic [tscs_pkg::CNT_W-1:0] free_len(
    input logic [7:0] v
  );
    logic [7:0] s;
    s = v;
    if (v < tscs_pkg::FREE_MIN || v > tscs_pkg::FREE_MAX)
      s = tscs_pkg::RST_FREE_CYC;
    free_len = tscs_pkg::CNT_W'(FREE_BASE_CYC) << (s - 8'h01);
  endfunction

  // Parameter array index of a subindex
  function automatic logic [3:0] prm_ix(input logic [7:0] sx);
    prm_ix = 4'(sx - 8'h01);
  endfunction

  logic [tscs_pkg::CNT_W-1:0] cyc_len;
  logic [tscs_pkg::CNT_W-1:0] smp_gap;
  logic [7:0]                 fact;
  logic [2:0]                 smp_n;
  logic                       iso_rise;
  logic                       iso_fall;
  logic                       boundary;
  logic                       take;
  logic                       sx_ok;

  // Module cycle length and sample spacing for the active settings
  always_comb
  begin
    fact     = (q.fact_act > tscs_pkg::FACT_MAX) ? tscs_pkg::FACT_UNITY
                                                 : q.fact_act;
    iso_rise = iso_mode && q.mode == tscs_pkg::MODE_FREE;
    iso_fall = !iso_mode && q.mode == tscs_pkg::MODE_ISO;
    if (q.mode == tscs_pkg::MODE_ISO)
    begin
      if (fact >= tscs_pkg::FACT_UNITY)
        cyc_len = q.bus_per << (fact - tscs_pkg::FACT_UNITY);
      else
        cyc_len = q.bus_per >> (tscs_pkg::FACT_UNITY - fact);
    end
    else
      cyc_len = free_len(q.prm[tscs_pkg::IX_FREE_CYC]);
    smp_gap = cyc_len >> ovs_shift(q.osr_act);
    smp_n   = 3'h1 << ovs_shift(q.osr_act);
  end

  // Cycle boundary: bus marker in iso mode (and own counter below unity factor), own counter otherwise
  always_comb
  begin
    boundary = 1'b0;
    unique case (q.mode)
      tscs_pkg::MODE_ISO:
      begin
        if (fact >= tscs_pkg::FACT_UNITY)
          boundary = bus_cycle &&
                     q.bus_cnt == 2'((3'h1 << (fact - 8'h02)) - 3'h1);
        else // Sub-cycles end early; the last one wins the bus read
          boundary = bus_cycle || (cyc_len != '0 &&
                     q.cyc_cnt >= cyc_len - 1'b1);
      end
      // Compare with >= so a shortened period ends the running cycle
      // at once instead of waiting for the counter to wrap
      tscs_pkg::MODE_FREE:
        boundary = q.cyc_cnt >= cyc_len - 1'b1;
    endcase
    take = boundary || (q.smp_idx < smp_n && smp_gap != '0 &&
           q.smp_cnt == smp_gap - 1'b1);
    sx_ok = fieldbus_subindex >= tscs_pkg::SX_DIAG_INTERRUPT_ENABLE &&
            fieldbus_subindex <= tscs_pkg::SX_LAST;
  end

  // Next state
  always_comb
  begin
    d = q;
    d.apply      = 1'b0;
    d.read       = 1'b0;
    d.img_valid  = 1'b0;
    d.smp_strobe = 1'b0;

    // Timer runs from start-up; head may reload it
    d.ns = q.ns + tscs_pkg::NS_STEP;
    if (timer_sync)
      d.ns = timer_sync_value;

    // Parameter access, one byte per subindex
    if (param_wr && sx_ok)
    begin
      d.prm[prm_ix(fieldbus_subindex)] = param_wdata;
      if (q.mode == tscs_pkg::MODE_ISO &&
          (fieldbus_subindex == tscs_pkg::SX_OVERSMPL ||
           fieldbus_subindex == tscs_pkg::SX_ISO_FACT))
        d.cfg_err = 1'b1;
    end
    if (param_rd)
      d.rdata = sx_ok ? q.prm[prm_ix(fieldbus_subindex)] : 8'h00;

    // Decoded enables kept in flops so the outputs are registered
    d.diag_on = d.prm[tscs_pkg::IX_DIAG_INTERRUPT_ENABLE] == tscs_pkg::DIAG_ON;
    d.wbrk    = d.prm[tscs_pkg::IX_WIRE_BRK][3:0];
    for (int ch = 0; ch < 4; ch++)
    begin
      d.ch_act[ch] =
        d.prm[tscs_pkg::IX_CH0_FN + 2 * ch] != tscs_pkg::CH_OFF;
    end

    // Oversampling follows the byte while free running
    if (q.mode == tscs_pkg::MODE_FREE)
      d.osr_act = q.prm[tscs_pkg::IX_OVERSMPL];

    // Mode changes apply pending settings and restart the cycle
    if (iso_rise || iso_fall)
    begin
      d.mode     = iso_rise ? tscs_pkg::MODE_ISO : tscs_pkg::MODE_FREE;
      d.osr_act  = q.prm[tscs_pkg::IX_OVERSMPL];
      d.cfg_err  = 1'b0;
      d.cyc_cnt  = '0;
      d.smp_cnt  = '0;
      d.bus_cnt  = 2'h0;
      if (iso_rise)
        d.fact_act = q.prm[tscs_pkg::IX_ISO_FACT];
    end
    else
    begin
      d.cyc_cnt = q.cyc_cnt + 1'b1;
      d.smp_cnt = q.smp_cnt + 1'b1;

      // Sampling grid within the cycle
      if (take)
      begin
        d.smp_cnt    = '0;
        d.smp_strobe = 1'b1;
        if (boundary)
        begin
          // Publish the finished cycle, start collecting the next
          d.img.samples   = q.buf_s;
          d.img.timestamp = q.ts_cur;
          d.img_valid     = 1'b1;
          d.ts_cur        = q.ns;
          d.cyc_cnt       = '0;
          d.buf_s         = '0;
        end
        for (int ch = 0; ch < 4; ch++)
        begin
          if (q.prm[tscs_pkg::IX_CH0_FN + 2 * ch] != tscs_pkg::CH_OFF)
            d.buf_s[ch * 4 + (boundary ? 0 : int'(q.smp_idx[1:0]))] =
              adc_data[ch];
        end
        d.smp_idx = boundary ? 3'h1 : q.smp_idx + 3'h1;
      end
    end

    // Bus period measurement and divider for slower factors
    d.bus_meas = q.bus_meas + 1'b1;
    if (bus_cycle)
    begin
      d.bus_per  = q.bus_meas + 1'b1;
      d.bus_meas = '0;
      if (q.mode == tscs_pkg::MODE_ISO && !iso_fall)
        d.bus_cnt = boundary ? 2'h0 : q.bus_cnt + 2'h1;
      d.dly_cnt = 12'h000;
      d.dly_run = q.mode == tscs_pkg::MODE_ISO;
    end
    else if (q.dly_run)
    begin
      // Provision delays from the reference point
      d.dly_cnt = q.dly_cnt + 12'h001;
      if (q.dly_cnt == tscs_pkg::OUT_DELAY_CYC - 12'h001)
        d.apply = 1'b1;
      if (q.dly_cnt == tscs_pkg::IN_DELAY_CYC - 12'h001)
      begin
        d.read    = 1'b1;
        d.dly_run = 1'b0;
      end
    end
  end

  // State register; parameters take their defaults at reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q <= '0;
      q.mode <= tscs_pkg::MODE_FREE;
      q.prm[tscs_pkg::IX_DIAG_INTERRUPT_ENABLE]  <= tscs_pkg::RST_DIAG_INTERRUPT_ENABLE;
      q.prm[tscs_pkg::IX_WIRE_BRK] <= tscs_pkg::RST_WIRE_BRK;
      q.prm[tscs_pkg::IX_FREE_CYC] <= tscs_pkg::RST_FREE_CYC;
      q.prm[tscs_pkg::IX_OVERSMPL] <= tscs_pkg::RST_OVERSMPL;
      q.prm[tscs_pkg::IX_ISO_FACT] <= tscs_pkg::RST_ISO_FACT;
      for (int ch = 0; ch < 4; ch++)
      begin
        q.prm[tscs_pkg::IX_CH0_FN + 2 * ch]     <= tscs_pkg::RST_CH_FN;
        q.prm[tscs_pkg::IX_CH0_FN + 2 * ch + 1] <= tscs_pkg::RST_CH_FILT;
      end
      q.osr_act  <= tscs_pkg::RST_OVERSMPL;
      q.fact_act <= tscs_pkg::RST_ISO_FACT;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign param_rdata           = q.rdata;
  assign input_image_area      = q.img;
  assign image_valid           = q.img_valid;
  assign sample_strobe         = q.smp_strobe;
  assign output_apply          = q.apply;
  assign input_read            = q.read;
  assign iso_config_error      = q.cfg_err;
  assign ns_timer              = q.ns;
  assign diag_interrupt_enable = q.diag_on;
  assign wire_break_enable     = q.wbrk;
  assign channel_active        = q.ch_act;

endmodule

`default_nettype wire

/* File: verilog/tscs_pkg.sv */
// Package for the timestamped sample capture scheduler.
// Holds parameter subindices, reset values, timing constants and the
// state and image structs. Assumes a 10 MHz device clock.
package tscs_pkg;

  // Device clock and timer step
  localparam int unsigned CLK_NS       = 100;
  localparam logic [31:0] NS_STEP      = 32'(CLK_NS);

  // Delays from the isochronous reference point
  localparam int unsigned OUT_DELAY_US = 200;
  localparam int unsigned IN_DELAY_US  = 230;
  localparam logic [11:0] OUT_DELAY_CYC = 12'((OUT_DELAY_US * 1000) / CLK_NS);
  localparam logic [11:0] IN_DELAY_CYC  = 12'((IN_DELAY_US * 1000) / CLK_NS);

  // Shortest free-running period, the 01h step
  localparam int unsigned FREE_BASE_NS = 62500;
  localparam int unsigned FREE_BASE_CYC = FREE_BASE_NS / CLK_NS;

  // Counter width for cycle lengths (bus period up to 104 ms at factor 04h)
  localparam int unsigned CNT_W = 22;

  // Parameter subindices (one byte each, starting at 01h)
  localparam logic [7:0] SX_DIAG_INTERRUPT_ENABLE   = 8'h01;
  localparam logic [7:0] SX_WIRE_BRK  = 8'h02;
  localparam logic [7:0] SX_FREE_CYC  = 8'h03;
  localparam logic [7:0] SX_OVERSMPL  = 8'h04;
  localparam logic [7:0] SX_ISO_FACT  = 8'h05;
  localparam logic [7:0] SX_CH0_FN    = 8'h06;
  localparam logic [7:0] SX_LAST      = 8'h0D;
  localparam int unsigned NUM_PARAMS  = 13;

  // Index of each byte in the parameter array (subindex minus one)
  localparam int unsigned IX_DIAG_INTERRUPT_ENABLE  = 0;
  localparam int unsigned IX_WIRE_BRK = 1;
  localparam int unsigned IX_FREE_CYC = 2;
  localparam int unsigned IX_OVERSMPL = 3;
  localparam int unsigned IX_ISO_FACT = 4;
  localparam int unsigned IX_CH0_FN   = 5;

  // Reset values
  localparam logic [7:0] RST_DIAG_INTERRUPT_ENABLE  = 8'h00;
  localparam logic [7:0] RST_WIRE_BRK = 8'h00;
  localparam logic [7:0] RST_FREE_CYC = 8'h05;
  localparam logic [7:0] RST_OVERSMPL = 8'h02;
  localparam logic [7:0] RST_ISO_FACT = 8'h02;
  localparam logic [7:0] RST_CH_FN    = 8'hFF;
  localparam logic [7:0] RST_CH_FILT  = 8'h00;

  // Encodings
  localparam logic [7:0] DIAG_ON      = 8'h40;
  localparam logic [7:0] CH_OFF       = 8'hFF;
  localparam logic [7:0] FREE_MIN     = 8'h01;
  localparam logic [7:0] FREE_MAX     = 8'h0A;
  localparam logic [7:0] OVS_MAX      = 8'h02;
  localparam logic [7:0] FACT_UNITY   = 8'h02;
  localparam logic [7:0] FACT_MAX     = 8'h04;

  typedef enum logic [1:0] {
    MODE_FREE = 2'b01,
    MODE_ISO  = 2'b10
  } tscs_mode_e;

  // Sixteen samples, channel-major, four slots per channel
  typedef logic [15:0][15:0] tscs_samples_t;

  typedef struct packed {
    tscs_samples_t samples;
    logic [31:0]   timestamp;
  } tscs_image_s;

  typedef struct packed {
    tscs_mode_e          mode;
    logic [31:0]         ns;
    logic [31:0]         ts_cur;
    tscs_samples_t       buf_s;
    tscs_image_s         img;
    logic [12:0][7:0]    prm;
    logic [CNT_W-1:0]    cyc_cnt;
    logic [CNT_W-1:0]    smp_cnt;
    logic [2:0]          smp_idx;
    logic [CNT_W-1:0]    bus_meas;
    logic [CNT_W-1:0]    bus_per;
    logic [1:0]          bus_cnt;
    logic [7:0]          osr_act;
    logic [7:0]          fact_act;
    logic                cfg_err;
    logic [11:0]         dly_cnt;
    logic                dly_run;
    logic                apply;
    logic                read;
    logic                img_valid;
    logic                smp_strobe;
    logic [7:0]          rdata;
    logic                diag_on;
    logic [3:0]          wbrk;
    logic [3:0]          ch_act;
  } tscs_state_s;

endpackage

/* File: tb/tscs_head_model.sv */
// Head module model: mode level, bus marker and timer sync.
// Assumes the bench raises run to start isochronous operation.
`timescale 1ns/10ps
`default_nettype none
module tscs_head_model #(
  parameter int unsigned PER = 2500
) (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [31:0] sync_val,
  output logic             iso_mode,
  output logic             bus_cycle,
  output logic             timer_sync,
  output logic [31:0]      timer_sync_value
);
  int cnt;

  initial
  begin
    iso_mode = 1'b0;
    bus_cycle = 1'b0;
    timer_sync = 1'b0;
    timer_sync_value = 32'h0;
    cnt = 0;
  end

  // Driven off the sampling edge; value bus inverted when unused
  always @(negedge clk)
  begin
    timer_sync <= run && !iso_mode;
    timer_sync_value <= (run && !iso_mode) ? sync_val : ~sync_val;
    bus_cycle <= run && cnt == 0;
    cnt <= (!run || cnt == PER - 1) ? 0 : cnt + 1;
    iso_mode <= run;
  end
endmodule
`default_nettype wire

/* File: tb/tscs_scheduler_chk.sv */
// Port checker for the capture scheduler.
// Bound to tscs_scheduler; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module tscs_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        iso_mode,
  input wire logic        bus_cycle,
  input wire logic        timer_sync,
  input wire logic [31:0] timer_sync_value,
  input wire logic        param_wr,
  input wire logic        param_rd,
  input wire logic [7:0]  fieldbus_subindex,
  input wire logic [7:0]  param_wdata,
  input wire logic [7:0]  param_rdata,
  input wire logic        image_valid,
  input wire logic        output_apply,
  input wire logic        input_read,
  input wire logic        iso_config_error,
  input wire logic [31:0] ns_timer,
  input wire logic [3:0]  channel_active,
  input wire logic        diag_interrupt_enable
);
  logic [11:0] since_bus_q;

  // Saturating age of the last bus marker, so no marker means no pulse
  always_ff @(posedge clk)
  begin
    if (reset)
      since_bus_q <= 12'hFFF;
    else if (bus_cycle)
      since_bus_q <= 12'h001;
    else if (since_bus_q != 12'hFFF)
      since_bus_q <= since_bus_q + 12'h001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_iso_cfg_write;
    iso_mode && $stable(iso_mode) && param_wr &&
    (fieldbus_subindex == 8'h04 || fieldbus_subindex == 8'h05);
  endsequence

  a_timer_step: assert property (
    !$past(reset) && !$past(timer_sync)
    |-> ns_timer == $past(ns_timer) + 32'h64)
    else $error("timer step wrong");
  a_sync_load: assert property (
    timer_sync |=> ns_timer == $past(timer_sync_value))
    else $error("timer sync not loaded");
  a_apply_delay: assert property (
    output_apply |-> since_bus_q >= 12'h7D0 && since_bus_q <= 12'h7D1)
    else $error("apply pulse misplaced");
  a_read_delay: assert property (
    input_read |-> since_bus_q >= 12'h8FC && since_bus_q <= 12'h8FD)
    else $error("read pulse misplaced");
  a_err_set: assert property (
    s_iso_cfg_write |=> iso_config_error)
    else $error("config error not raised");
  a_err_free: assert property (
    !iso_mode && !$past(iso_mode) && !$past(iso_mode, 2)
    |-> !iso_config_error)
    else $error("config error outside iso");
  a_diag_enable: assert property (
    param_wr && fieldbus_subindex == 8'h01
    |=> diag_interrupt_enable == ($past(param_wdata) == 8'h40))
    else $error("diag enable wrong");
  a_chan_active: assert property (
    param_wr && fieldbus_subindex == 8'h06
    |=> channel_active[0] == ($past(param_wdata) != 8'hFF))
    else $error("channel active wrong");
  a_unmapped_read: assert property (
    param_rd && (fieldbus_subindex == 8'h00 || fieldbus_subindex > 8'h0D)
    |=> param_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_image_pulse: assert property (
    image_valid |=> !image_valid)
    else $error("image valid too long");
endmodule

bind tscs_scheduler tscs_chk tscs_chk_inst (
  .clk(clk), .reset(reset), .iso_mode(iso_mode), .bus_cycle(bus_cycle),
  .timer_sync(timer_sync), .timer_sync_value(timer_sync_value),
  .param_wr(param_wr), .param_rd(param_rd),
  .fieldbus_subindex(fieldbus_subindex), .param_wdata(param_wdata),
  .param_rdata(param_rdata), .image_valid(image_valid),
  .output_apply(output_apply), .input_read(input_read),
  .iso_config_error(iso_config_error), .ns_timer(ns_timer),
  .channel_active(channel_active),
  .diag_interrupt_enable(diag_interrupt_enable)
);
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the capture scheduler.
// Assumes the head model drives mode, bus marker and timer sync.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                  clk;
  logic                  reset;
  logic                  run;
  logic                  wr_q;
  logic                  rd_q;
  logic [7:0]            sx;
  logic [7:0]            wd;
  logic [3:0][15:0]      adc;
  logic                  iso;
  logic                  bus;
  logic                  tsync;
  logic [31:0]           tval;
  logic [7:0]            rdata;
  tscs_pkg::tscs_image_s img;
  logic                  iv;
  logic                  strobe;
  logic                  apply;
  logic                  iread;
  logic                  cfg_err;
  logic [31:0]           ns;
  logic [3:0]            chan;
  logic                  diag;
  logic [3:0]            wbrk;
  int                    fails;
  int                    compares;
  int                    cyc;
  int                    strobes;
  int                    pulses;

  tscs_head_model tscs_head_model_inst (.clk(clk), .run(run),
    .sync_val(32'hFFFFF000), .iso_mode(iso), .bus_cycle(bus),
    .timer_sync(tsync), .timer_sync_value(tval));

  tscs_scheduler #(.FREE_BASE_CYC(8)) tscs_scheduler_inst (.clk(clk),
    .reset(reset), .iso_mode(iso), .bus_cycle(bus), .timer_sync(tsync),
    .timer_sync_value(tval), .adc_data(adc), .param_wr(wr_q),
    .param_rd(rd_q), .fieldbus_subindex(sx), .param_wdata(wd),
    .param_rdata(rdata), .input_image_area(img), .image_valid(iv),
    .sample_strobe(strobe), .output_apply(apply), .input_read(iread),
    .iso_config_error(cfg_err), .ns_timer(ns), .channel_active(chan),
    .diag_interrupt_enable(diag), .wire_break_enable(wbrk));

  // 100 ns clock
  always #50 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard; the full run needs about 33000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 70000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    @(negedge clk);
    sx = s;
    wd = d;
    wr_q = 1'b1;
    @(negedge clk);
    wr_q = 1'b0;
  endtask

  task automatic rd(input logic [7:0] s, output logic [7:0] d);
    @(negedge clk);
    sx = s;
    rd_q = 1'b1;
    @(negedge clk);
    rd_q = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // Waits for the next image, counting strobes and delay pulses
  task automatic wiv;
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      strobes += int'(strobe);
      pulses += int'(apply) + int'(iread);
    end
    while (iv !== 1'b1 && n < 6000);
    // A missing image is a failure in its own right
    if (iv !== 1'b1)
      fails++;
  endtask

  task automatic meas(output int p, output logic [31:0] dt);
    int t0;
    logic [31:0] ts0;
    wiv();
    t0 = cyc;
    ts0 = img.timestamp;
    strobes = 0;
    pulses = 0;
    wiv();
    p = cyc - t0;
    dt = img.timestamp - ts0;
  endtask

  task automatic t_params;
    logic [7:0] d;
    for (int s = 0; s < 15; s++)
    begin
      rd(8'(s), d);
      check(d, (s == 3) ? 8'h05 : (s == 4 || s == 5) ? 8'h02 :
        (s > 5 && s < 13 && s % 2 == 0) ? 8'hFF : 8'h00);
    end
    check(chan, 4'h0);
    wr(8'h01, 8'h40);
    check(diag, 1'b1);
    wr(8'h01, 8'h00);
    check(diag, 1'b0);
    wr(8'h02, 8'h0F);
    check(wbrk, 4'hF);
    wr(8'h0E, 8'h55);
    wr(8'h05, 8'h03);
    rd(8'h05, d);
    check(d, 8'h03);
    $display("parameter test done");
  endtask

  task automatic t_free;
    int p;
    logic [31:0] dt;
    wr(8'h06, 8'h12);
    wr(8'h08, 8'h12);
    check(chan, 4'h3);
    for (int f = 1; f < 4; f++)
    begin
      wr(8'h03, 8'(f));
      wiv();
      meas(p, dt);
      check(32'(p), 32'(8 << (f - 1)));
      check(dt, 32'(800 << (f - 1)));
    end
    check(img.samples[3], 16'h1111);
    check(img.samples[8], 16'h0000);
    for (int o = 0; o < 3; o++)
    begin
      wr(8'h04, 8'(o));
      wiv();
      meas(p, dt);
      check(32'(strobes), 32'(1 << o));
    end
    wiv();
    adc[0] = 16'hABCD;
    wiv();
    check(img.samples[0], 16'h1111);
    wiv();
    check(img.samples[0], 16'hABCD);
    wr(8'h05, 8'h02);
    $display("free running test done");
  endtask

  task automatic t_iso;
    int p;
    logic [31:0] dt;
    run = 1'b1;
    wiv();
    meas(p, dt);
    check(32'(p), 32'd2500);
    check(dt, 32'd250000);
    check(32'(pulses), 32'd2);
    wr(8'h03, 8'h0A);
    wr(8'h05, 8'h01);
    check(cfg_err, 1'b1);
    wr(8'h04, 8'h02);
    meas(p, dt);
    check(32'(p), 32'd2500);
    run = 1'b0;
    wiv();
    meas(p, dt);
    check(cfg_err, 1'b0);
    check(32'(p), 32'd4096);
    run = 1'b1;
    repeat (3) wiv();
    meas(p, dt);
    check(32'(p), 32'd1250);
    $display("isochronous test done");
  endtask

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    run = 1'b0;
    wr_q = 1'b0;
    rd_q = 1'b0;
    sx = 8'h00;
    wd = 8'h00;
    adc = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
    fails = 0;
    compares = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_params();
    t_free();
    t_iso();
    conclude();
  end
endmodule
`default_nettype wire
